// >>> hdl/lpss_pkg.sv
// Constants and types for the laser pulse schedule sequencer.
// Assumes a 100 MHz core clock; all timing counts derive from it.
package lpss_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Timebase tick of 0.01 ms, the resolution of all schedule times
  localparam int TICK_NS       = 10000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int SEC_NS        = 1000000000;
  localparam int SEC_TICKS     = SEC_NS / TICK_NS;
  localparam int N_SCHED       = 32;
  localparam int N_SEG         = 3;
  localparam int N_FADE        = 6;
  localparam int TIME_W        = 9;   // 0.01 ms units, up to 5.00 ms
  localparam int PCT_W         = 11;  // 0.1 % units, up to 150.0 %
  localparam int PEAK_W        = 8;   // 0.01 kW units, up to 1.50 kW
  localparam int RATE_W        = 5;   // 0 to 30 pps
  localparam int SHOT_W        = 14;  // 0 to 9999
  localparam int PWR_W         = 10;  // Output power, 0.01 kW units
  localparam int GAP_W         = 17;
  localparam int TICKC_W       = 10;
  localparam int PWR_DIV       = 1000000;
  localparam logic [PCT_W-1:0] PCT_FULL = 11'h03e8;
  // Write port field codes
  localparam logic [3:0] FLD_TIME0    = 4'h0;
  localparam logic [3:0] FLD_TIME2    = 4'h2;
  localparam logic [3:0] FLD_PCT0     = 4'h3;
  localparam logic [3:0] FLD_PCT2     = 4'h5;
  localparam logic [3:0] FLD_UP       = 4'h6;
  localparam logic [3:0] FLD_DOWN     = 4'h7;
  localparam logic [3:0] FLD_RATE     = 4'h8;
  localparam logic [3:0] FLD_SHOTS    = 4'h9;
  localparam logic [3:0] FLD_FADE     = 4'ha;
  localparam logic [3:0] FLD_PEAK     = 4'hb;
  localparam logic [3:0] FLD_FADE_CNT = 4'hc;
  localparam logic [3:0] FLD_FADE_PCT = 4'hd;
  localparam int SYNC_W = 5;
  typedef enum logic [1:0] {LPSS_IDLE, LPSS_FIRE, LPSS_GAP} lpss_state_t;
endpackage

// >>> hdl/lpss_sequencer.sv
// Laser pulse schedule sequencer: schedule store, pulse shaper, shot sequencer.
// Assumes start/stop/error and switch bits arrive from pins, schedule writes
// come from logic on core_clk_i.
// Notes on behaviour
// RULE_01 - Thirty-two schedules, pulse follows the selected one
// RULE_02 - Pulse built from up to three segments
// RULE_03 - Segment time 0-5 ms, power is percent
// RULE_04 - Controller keeps total segment time 0.2-5 ms
// RULE_05 - Controller keeps peak power at most 1.5 kW
// RULE_06 - Linear up ramp inside first segment
// RULE_07 - Linear down ramp inside last segment
// RULE_08 - Rate 0-30 pps, zero gives single pulse
// RULE_09 - Shot count 0-9999, one gives one pulse
// RULE_10 - Nonzero rate, zero count: run until stop
// RULE_11 - Seam fade flag applies fade power table
// RULE_12 - End output once after all shots, if enabled
// RULE_13 - End output also on error or stop
// RULE_14 - Switch bit judges monitor on every faded shot
// RULE_15 - Switch bits take effect only after reset
// RULE_16 - Stop output when count reaches shot count
// RULE_17 - Fade: judge only full-power shots by default
// RULE_18 - Common timebase, linear ramps
// RULE_19 - Shot counter cleared on every start
`timescale 1ns/1ns
module lpss_sequencer (
  input  wire logic                         core_clk_i,
  input  wire logic                         resetn_i,
  input  wire logic                         ce_i,
  input  wire logic                         start_pin_i,
  input  wire logic                         stop_pin_i,
  input  wire logic                         error_pin_i,
  input  wire logic                         end_sw_pin_i,
  input  wire logic                         mon_all_sw_pin_i,
  input  wire logic [4:0]                   sched_sel_i,
  input  wire logic                         wr_en_i,
  input  wire logic [4:0]                   wr_sched_i,
  input  wire logic [3:0]                   wr_field_i,
  input  wire logic [lpss_pkg::SHOT_W-1:0]  wr_data_i,
  output logic      [lpss_pkg::PWR_W-1:0]   power_o,
  output logic                              firing_o,
  output logic                              busy_o,
  output logic      [lpss_pkg::SHOT_W-1:0]  shot_cnt_o,
  output logic                              end_o,
  output logic                              mon_judge_o
);
  localparam int TW = lpss_pkg::TIME_W;
  localparam int PW = lpss_pkg::PCT_W;

  // Linear ramp: level scaled by num/den
  function automatic logic [PW-1:0] ramp(input logic [PW-1:0] lvl,
                                         input logic [TW-1:0] num,
                                         input logic [TW-1:0] den);
    logic [31:0] p;
    p = 32'(lvl) * 32'(num) / 32'(den);
    return p[PW-1:0];
  endfunction

  logic [2:0][TW-1:0]            t_mem [lpss_pkg::N_SCHED];
  logic [2:0][PW-1:0]            p_mem [lpss_pkg::N_SCHED];
  logic [TW-1:0]                 up_mem [lpss_pkg::N_SCHED];
  logic [TW-1:0]                 dn_mem [lpss_pkg::N_SCHED];
  logic [lpss_pkg::RATE_W-1:0]   rate_mem [lpss_pkg::N_SCHED];
  logic [lpss_pkg::SHOT_W-1:0]   shots_mem [lpss_pkg::N_SCHED];
  logic [lpss_pkg::PEAK_W-1:0]   peak_mem [lpss_pkg::N_SCHED];
  logic [lpss_pkg::N_SCHED-1:0]  fade_mem;
  logic [lpss_pkg::SHOT_W-1:0]   fcnt_mem [lpss_pkg::N_FADE];
  logic [PW-1:0]                 fpct_mem [lpss_pkg::N_FADE];

  logic [lpss_pkg::SYNC_W-1:0]   s1_reg;
  logic [lpss_pkg::SYNC_W-1:0]   s2_reg;
  logic                          start_prev_reg;
  logic [1:0]                    cfg_cnt_reg;
  logic                          cfg_done_reg;
  logic                          end_sw_reg;
  logic                          mon_all_reg;
  lpss_pkg::lpss_state_t         state_reg;
  logic [4:0]                    cur_reg;
  logic [1:0]                    seg_reg;
  logic [TW-1:0]                 seg_cnt_reg;
  logic [TW-1:0]                 elap_reg;
  logic [lpss_pkg::GAP_W-1:0]    gap_reg;
  logic [lpss_pkg::TICKC_W-1:0]  tick_reg;
  logic [lpss_pkg::SHOT_W-1:0]   shot_cnt_reg;
  logic                          end_reg;
  logic [lpss_pkg::PWR_W-1:0]    power_reg;
  logic                          mon_reg;

  // Synchronised pin levels
  wire start_s = s2_reg[0];
  wire stop_s  = s2_reg[1];
  wire err_s   = s2_reg[2];
  wire start_edge = start_s & ~start_prev_reg;
  wire tick_hit = tick_reg == lpss_pkg::TICKC_W'(lpss_pkg::TICK_CYC - 1);

  // Write decode
  wire [1:0] wr_idx = wr_field_i[1:0] - (wr_field_i >= lpss_pkg::FLD_PCT0 ? 2'h3 : 2'h0);
  wire wr_time = wr_en_i && wr_field_i <= lpss_pkg::FLD_TIME2;
  wire wr_pct  = wr_en_i && wr_field_i >= lpss_pkg::FLD_PCT0 && wr_field_i <= lpss_pkg::FLD_PCT2;
  wire [2:0] wr_fpt = wr_sched_i[2:0];

  // Active schedule view [RULE_01]
  wire [TW-1:0] t0 = t_mem[cur_reg][0];
  wire [TW-1:0] t1 = t_mem[cur_reg][1];
  wire [TW-1:0] t2 = t_mem[cur_reg][2];
  wire [TW-1:0] up_t = up_mem[cur_reg];
  wire [TW-1:0] dn_t = dn_mem[cur_reg];
  wire [lpss_pkg::RATE_W-1:0] rate = rate_mem[cur_reg];
  wire [lpss_pkg::SHOT_W-1:0] shots = shots_mem[cur_reg];
  wire fade_on = fade_mem[cur_reg];
  wire [TW-1:0] seg_t = t_mem[cur_reg][seg_reg];
  wire [PW-1:0] seg_p = p_mem[cur_reg][seg_reg];

  // First nonzero segment of a schedule's time triple
  function automatic logic [1:0] seg_first(input logic [2:0][TW-1:0] t);
    return t[0] != '0 ? 2'h0 : (t[1] != '0 ? 2'h1 : 2'h2);
  endfunction

  // Zero-length segments are skipped [RULE_02]
  // Start looks at the schedule being selected, not the one used last
  wire [1:0] first_seg = seg_first(t_mem[cur_reg]);
  wire [1:0] start_seg = seg_first(t_mem[sched_sel_i]);
  wire [1:0] last_seg  = t2 != '0 ? 2'h2 : (t1 != '0 ? 2'h1 : 2'h0);
  wire [1:0] next_seg  = (seg_reg == 2'h0 && t1 != '0) ? 2'h1 : 2'h2;
  wire seg_end   = tick_hit && (seg_cnt_reg + 1'b1 >= seg_t);
  wire pulse_end = seg_end && seg_reg == last_seg;
  wire [TW-1:0] remain = seg_t - seg_cnt_reg;

  // Level with ramps [RULE_06] [RULE_07] [RULE_18]
  wire in_up = up_t != '0 && elap_reg < up_t;
  wire in_dn = dn_t != '0 && seg_reg == last_seg && remain <= dn_t;
  wire [PW-1:0] lvl_w = in_up ? ramp(seg_p, elap_reg, up_t) :
                        in_dn ? ramp(seg_p, remain, dn_t) : seg_p;

  // Fade table: last point reached by this shot number governs [RULE_11]
  wire [lpss_pkg::SHOT_W-1:0] shot_no = shot_cnt_reg + 1'b1;
  logic [PW-1:0] fade_tab;
  always_comb begin
    fade_tab = lpss_pkg::PCT_FULL;
    for (int i = 0; i < lpss_pkg::N_FADE; i++) begin
      if (fcnt_mem[i] != '0 && fcnt_mem[i] <= shot_no) begin
        fade_tab = fpct_mem[i];
      end
    end
  end
  wire [PW-1:0] fade_w = fade_on ? fade_tab : lpss_pkg::PCT_FULL;  // [RULE_11]

  // Peak in 0.01 kW times two per-mille factors [RULE_03]
  wire [31:0] pwr_prod = 32'(peak_mem[cur_reg]) * 32'(lvl_w) * 32'(fade_w) / 32'(lpss_pkg::PWR_DIV);
  wire [lpss_pkg::PWR_W-1:0] pwr_w = pwr_prod[lpss_pkg::PWR_W-1:0];

  // Repetition interval in ticks; rate 0 never reaches the gap state
  wire [lpss_pkg::GAP_W-1:0] interval = rate == '0 ? '0 :
    lpss_pkg::GAP_W'(lpss_pkg::SEC_TICKS / int'(rate));  // [RULE_08] [RULE_18]
  wire done = rate == '0 || (shots != '0 && shot_no == shots);  // [RULE_08] [RULE_09] [RULE_16]
  wire abort = (stop_s || err_s) && state_reg != lpss_pkg::LPSS_IDLE;
  wire judge = !fade_on || fade_w == lpss_pkg::PCT_FULL || mon_all_reg;  // [RULE_14] [RULE_17]

  // Schedule store
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < lpss_pkg::N_SCHED; i++) begin
        t_mem[i] <= '0;
        p_mem[i] <= '0;
        up_mem[i] <= '0;
        dn_mem[i] <= '0;
        rate_mem[i] <= '0;
        shots_mem[i] <= '0;
        peak_mem[i] <= '0;
      end
      for (int i = 0; i < lpss_pkg::N_FADE; i++) begin
        fcnt_mem[i] <= '0;
        fpct_mem[i] <= '0;
      end
      fade_mem <= '0;
    end else if (ce_i) begin
      if (wr_time) t_mem[wr_sched_i][wr_idx] <= wr_data_i[TW-1:0];
      if (wr_pct) p_mem[wr_sched_i][wr_idx] <= wr_data_i[PW-1:0];
      if (wr_en_i) begin
        case (wr_field_i)
          lpss_pkg::FLD_UP:       up_mem[wr_sched_i] <= wr_data_i[TW-1:0];
          lpss_pkg::FLD_DOWN:     dn_mem[wr_sched_i] <= wr_data_i[TW-1:0];
          lpss_pkg::FLD_RATE:     rate_mem[wr_sched_i] <= wr_data_i[lpss_pkg::RATE_W-1:0];
          lpss_pkg::FLD_SHOTS:    shots_mem[wr_sched_i] <= wr_data_i;
          lpss_pkg::FLD_FADE:     fade_mem[wr_sched_i] <= wr_data_i[0];
          lpss_pkg::FLD_PEAK:     peak_mem[wr_sched_i] <= wr_data_i[lpss_pkg::PEAK_W-1:0];
          lpss_pkg::FLD_FADE_CNT: if (wr_fpt < 3'h6) fcnt_mem[wr_fpt] <= wr_data_i;
          lpss_pkg::FLD_FADE_PCT: if (wr_fpt < 3'h6) fpct_mem[wr_fpt] <= wr_data_i[PW-1:0];
          default: ;
        endcase
      end
    end
  end

  // Pin synchronisers and switch capture after power-up
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      start_prev_reg <= 1'b0;
      cfg_cnt_reg <= '0;
      cfg_done_reg <= 1'b0;
      end_sw_reg <= 1'b0;
      mon_all_reg <= 1'b0;
    end else if (ce_i) begin
      s1_reg <= {mon_all_sw_pin_i, end_sw_pin_i, error_pin_i, stop_pin_i, start_pin_i};
      s2_reg <= s1_reg;
      start_prev_reg <= start_s;
      // Wait for the synchroniser to fill, then freeze until next reset
      if (!cfg_done_reg) begin
        cfg_cnt_reg <= cfg_cnt_reg + 1'b1;
        if (cfg_cnt_reg == 2'h2) begin
          cfg_done_reg <= 1'b1;  // [RULE_15]
          end_sw_reg <= s2_reg[3];
          mon_all_reg <= s2_reg[4];
        end
      end
    end
  end

  // Shot sequencer
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= lpss_pkg::LPSS_IDLE;
      cur_reg <= '0;
      seg_reg <= '0;
      seg_cnt_reg <= '0;
      elap_reg <= '0;
      gap_reg <= '0;
      tick_reg <= '0;
      shot_cnt_reg <= '0;
      end_reg <= 1'b0;
      power_reg <= '0;
      mon_reg <= 1'b0;
    end else if (ce_i) begin
      tick_reg <= tick_hit ? '0 : tick_reg + 1'b1;
      if (tick_hit) end_reg <= 1'b0;
      power_reg <= state_reg == lpss_pkg::LPSS_FIRE ? pwr_w : '0;
      mon_reg <= state_reg == lpss_pkg::LPSS_FIRE && judge;
      if (tick_hit && state_reg != lpss_pkg::LPSS_IDLE) gap_reg <= gap_reg + 1'b1;
      case (state_reg)
        lpss_pkg::LPSS_IDLE: begin
          if (start_edge && cfg_done_reg && !stop_s && !err_s) begin
            state_reg <= lpss_pkg::LPSS_FIRE;
            cur_reg <= sched_sel_i;  // [RULE_01]
            shot_cnt_reg <= '0;  // [RULE_19]
            seg_reg <= start_seg;  // [RULE_01] [RULE_02]
            seg_cnt_reg <= '0;
            elap_reg <= '0;
            gap_reg <= '0;
          end
        end
        lpss_pkg::LPSS_FIRE: begin
          if (tick_hit) begin
            elap_reg <= elap_reg + 1'b1;
            seg_cnt_reg <= seg_end ? '0 : seg_cnt_reg + 1'b1;
            if (seg_end && !pulse_end) seg_reg <= next_seg;  // [RULE_02]
          end
          if (pulse_end) begin
            shot_cnt_reg <= shot_no;  // [RULE_16]
            // Zero shot count with nonzero rate never completes [RULE_10]
            state_reg <= done ? lpss_pkg::LPSS_IDLE : lpss_pkg::LPSS_GAP;
          end
        end
        lpss_pkg::LPSS_GAP: begin
          if (tick_hit && gap_reg + 1'b1 >= interval) begin
            state_reg <= lpss_pkg::LPSS_FIRE;
            seg_reg <= first_seg;
            seg_cnt_reg <= '0;
            elap_reg <= '0;
            gap_reg <= '0;
          end
        end
        default: state_reg <= lpss_pkg::LPSS_IDLE;
      endcase
      // Stop or error ends the sequence at once [RULE_10] [RULE_13]
      if (abort) state_reg <= lpss_pkg::LPSS_IDLE;
      // Set wins over the tick clear; held until the next timebase tick
      if (end_sw_reg && (abort || (pulse_end && done && state_reg == lpss_pkg::LPSS_FIRE))) begin
        end_reg <= 1'b1;  // [RULE_12] [RULE_13]
      end
    end
  end

  assign power_o     = power_reg;
  assign firing_o    = state_reg == lpss_pkg::LPSS_FIRE;
  assign busy_o      = state_reg != lpss_pkg::LPSS_IDLE;
  assign shot_cnt_o  = shot_cnt_reg;
  assign end_o       = end_reg;
  assign mon_judge_o = mon_reg;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  a_sched_held: assert property (busy_o && ce_i |=> cur_reg == $past(cur_reg))  // [RULE_01]
    else $error("Schedule changed during a sequence");
  a_seg_nonzero: assert property (firing_o |-> seg_t != '0 || (t0 == '0 && t1 == '0 && t2 == '0))  // [RULE_03]
    else $error("Zero-length segment is firing");
  a_seg_order: assert property (firing_o && ce_i && seg_end && !pulse_end |=> seg_reg > $past(seg_reg))  // [RULE_02]
    else $error("Segments not taken in order");
  a_up_start: assert property (firing_o && elap_reg == '0 && up_t != '0 |-> lvl_w == '0)  // [RULE_06]
    else $error("Up ramp does not start from zero");
  a_single_shot: assert property (firing_o && ce_i && pulse_end && !abort && rate == '0 |=> !busy_o)  // [RULE_08]
    else $error("Rate zero produced more than one pulse");
  a_count_stop: assert property (busy_o |-> shots == '0 || shot_cnt_reg < shots)  // [RULE_16]
    else $error("Output continues past the shot count");
  a_start_clear: assert property (!busy_o && ce_i && start_edge && cfg_done_reg && !stop_s && !err_s
    |=> firing_o && shot_cnt_reg == '0)  // [RULE_19]
    else $error("Shot counter not cleared at start");
  a_fade_off: assert property (!fade_on |-> fade_w == lpss_pkg::PCT_FULL)  // [RULE_11]
    else $error("Fade applied with flag clear");
  a_end_gate: assert property ($rose(end_reg) |-> end_sw_reg && !busy_o)  // [RULE_12]
    else $error("End output without enable or while busy");
  a_stop_abort: assert property (busy_o && ce_i && stop_s |=> !busy_o ##0 (end_reg == end_sw_reg))  // [RULE_13]
    else $error("Stop did not end the sequence");
  a_mon_gate: assert property (mon_reg && fade_on && !mon_all_reg |-> $past(fade_w) == lpss_pkg::PCT_FULL)  // [RULE_17]
    else $error("Monitor judged on a faded shot");
  a_cfg_frozen: assert property (cfg_done_reg |=> $stable(end_sw_reg) && $stable(mon_all_reg))  // [RULE_15]
    else $error("Switch bits changed without reset");
endmodule

// >>> sim/lpss_plc_model.sv
// Model of the external controller that drives the start, stop and error pins.
// Assumes the bench calls its tasks from one process on the core clock.
`timescale 1ns/1ns
module lpss_plc_model (
  input  wire logic clk_i,
  output logic      start_o,
  output logic      stop_o,
  output logic      error_o
);
  initial begin
    start_o = 1'b0;
    stop_o  = 1'b0;
    error_o = 1'b0;
  end
  // Start held several cycles so the pin survives the input synchroniser
  task automatic start();
    @(posedge clk_i);
    start_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    start_o <= 1'b0;
  endtask
  // Kind 1 is a stop request, anything else an output error
  task automatic abort(input int kind);
    @(posedge clk_i);
    if (kind == 1) begin
      stop_o <= 1'b1;
    end else begin
      error_o <= 1'b1;
    end
  endtask
  // Stop is a level and blocks starts, so drop it once the sequence is over
  task automatic release_all();
    @(posedge clk_i);
    stop_o  <= 1'b0;
    error_o <= 1'b0;
  endtask
endmodule

// >>> sim/lpss_sequencer_tb.sv
// Self-checking bench for the laser pulse schedule sequencer.
// Assumes the controller model beside it and a 100 MHz core clock.
`timescale 1ns/1ns
module lpss_sequencer_tb;
  typedef struct {logic [15:0] shots, pmax, pmin, judge, endv; int fmin, fmax;} lpss_exp_t;
  logic core_clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, end_sw_pin_i = 1'b1, mon_all_sw_pin_i = 1'b0;
  logic wr_en_i = 1'b0;
  logic [4:0] sched_sel_i = 5'h00, wr_sched_i = 5'h00;
  logic [3:0] wr_field_i = 4'h0;
  logic [13:0] wr_data_i = 14'h0000;
  logic [9:0] power_o;
  logic firing_o, busy_o, end_o, mon_judge_o, start_w, stop_w, error_w;
  logic [13:0] shot_cnt_o;
  logic [31:0] rnd = 32'h2ecd_8509;
  lpss_exp_t q[$];
  int errors = 0, check_count = 0, cyc = 0;
  always #5 core_clk_i = ~core_clk_i;
  lpss_plc_model plc (.clk_i(core_clk_i), .start_o(start_w), .stop_o(stop_w), .error_o(error_w));
  lpss_sequencer dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .start_pin_i(start_w),
    .stop_pin_i(stop_w), .error_pin_i(error_w), .end_sw_pin_i(end_sw_pin_i),
    .mon_all_sw_pin_i(mon_all_sw_pin_i), .sched_sel_i(sched_sel_i), .wr_en_i(wr_en_i),
    .wr_sched_i(wr_sched_i), .wr_field_i(wr_field_i), .wr_data_i(wr_data_i), .power_o(power_o),
    .firing_o(firing_o), .busy_o(busy_o), .shot_cnt_o(shot_cnt_o), .end_o(end_o), .mon_judge_o(mon_judge_o));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic summarize();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [4:0] s, input logic [3:0] f, input logic [13:0] d);
    @(posedge core_clk_i);
    wr_en_i <= 1'b1;
    wr_sched_i <= s;
    wr_field_i <= f;
    wr_data_i <= d;
    @(posedge core_clk_i);
    wr_en_i <= 1'b0;
  endtask
  // Times keep 0.20 ms <= total <= 5.00 ms, ramps within segments, peak <= 1.50 kW
  task automatic cfg(input logic [4:0] s, input logic [13:0] up, dn, rate, shots, fade, peak, p1);
    wr(s, lpss_pkg::FLD_TIME0, 14'h000a);
    wr(s, 4'h1, 14'h000a);
    wr(s, lpss_pkg::FLD_TIME2, 14'h0000);
    wr(s, lpss_pkg::FLD_PCT0, 14'h03e8);
    wr(s, 4'h4, p1);
    wr(s, lpss_pkg::FLD_UP, up);
    wr(s, lpss_pkg::FLD_DOWN, dn);
    wr(s, lpss_pkg::FLD_RATE, rate);
    wr(s, lpss_pkg::FLD_SHOTS, shots);
    wr(s, lpss_pkg::FLD_FADE, fade);
    wr(s, lpss_pkg::FLD_PEAK, peak);
    wr(5'h00, lpss_pkg::FLD_FADE_CNT, 14'h0001);
    wr(5'h00, lpss_pkg::FLD_FADE_PCT, 14'h01f4);
    // Random traffic to schedules that no scenario selects
    repeat (3) begin
      rnd = lfsr_next(rnd);
      wr(5'(10 + rnd[7:0] % 22), 4'(rnd[15:8] % 10), rnd[29:16]);
    end
  endtask
  task automatic run(input logic [4:0] sel, input lpss_exp_t e, input int ab, input int ab_cyc);
    int n;
    q.push_back(e);
    @(posedge core_clk_i);
    sched_sel_i <= sel;
    plc.start();
    if (ab != 0) begin
      repeat (ab_cyc) @(posedge core_clk_i);
      chk("busy", 16'h0001, 16'(busy_o));
      plc.abort(ab);
    end
    n = 0;
    while (busy_o !== 1'b0 && n < 60000) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n == 60000) errors++;
    repeat (20) @(posedge core_clk_i);
    plc.release_all();
    repeat (10) @(posedge core_clk_i);
  endtask
  initial begin : watch
    lpss_exp_t e;
    logic [9:0] pmx, pmn;
    logic jd, en, pf;
    int fc;
    forever begin
      @(negedge core_clk_i);
      if (busy_o === 1'b1) begin
        pmx = 10'h000; pmn = 10'h3ff; jd = 1'b0; en = 1'b0; pf = 1'b0; fc = 0;
        while (busy_o === 1'b1) begin
          if (firing_o === 1'b1 && pf) begin
            if (power_o > pmx) pmx = power_o;
            if (power_o < pmn) pmn = power_o;
          end
          pf = (firing_o === 1'b1);
          fc += int'(pf);
          jd |= (mon_judge_o === 1'b1);
          en |= (end_o === 1'b1);
          @(negedge core_clk_i);
        end
        repeat (4) begin
          en |= (end_o === 1'b1);
          @(negedge core_clk_i);
        end
        if (q.size() == 0) errors++;
        else begin
          e = q.pop_front();
          chk("shots", e.shots, 16'(shot_cnt_o));
          chk("pmax", e.pmax, 16'(pmx));
          chk("pmin", e.pmin, 16'(pmn));
          chk("judge", e.judge, 16'(jd));
          chk("end", e.endv, 16'(en));
          chk_rng("fire", e.fmin, e.fmax, fc);
        end
      end
    end
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 99000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    // Rate zero gives one pulse even with five shots; down ramp over the last segment
    cfg(5'h05, 14'h0000, 14'h000a, 14'h0000, 14'h0005, 14'h0000, 14'h0078, 14'h00fa);
    run(5'h05, '{16'h0001, 16'h0078, 16'h0003, 16'h0001, 16'h0001, 19000, 21000}, 0, 0);
    // Switch change ignored until the next reset; faded schedule on index 9
    end_sw_pin_i <= 1'b0;
    cfg(5'h09, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0001, 14'h0096, 14'h0190);
    run(5'h09, '{16'h0001, 16'h004b, 16'h001e, 16'h0000, 16'h0001, 19000, 21000}, 0, 0);
    // Up ramp over the whole first segment, count of one ends the run
    // Ramp peaks at nine tenths of the first segment level
    cfg(5'h05, 14'h000a, 14'h0000, 14'h001e, 14'h0001, 14'h0000, 14'h0078, 14'h00fa);
    run(5'h05, '{16'h0001, 16'h006c, 16'h0000, 16'h0001, 16'h0001, 19000, 21000}, 0, 0);
    // Continuous mode stopped in the gap after the first pulse
    cfg(5'h05, 14'h0000, 14'h0000, 14'h001e, 14'h0000, 14'h0000, 14'h0078, 14'h00fa);
    run(5'h05, '{16'h0001, 16'h0078, 16'h001e, 16'h0001, 16'h0001, 19000, 21000}, 1, 25000);
    // Second power cycle with every faded shot judged, error mid-pulse
    mon_all_sw_pin_i <= 1'b1;
    end_sw_pin_i <= 1'b1;
    resetn_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    cfg(5'h09, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0001, 14'h0096, 14'h0190);
    run(5'h09, '{16'h0000, 16'h004b, 16'h004b, 16'h0001, 16'h0001, 4500, 6000}, 2, 5000);
    summarize();
  end
endmodule
